/* host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock and start
  input wire logic clk_sys,
  input wire logic go,
  // Controller side
  input wire logic [7:0] ack_data,
  input wire logic ack_data_oe,
  input wire logic slave_enable,
  output logic irq_acknowledge_n,
  // Captured answer
  output logic [7:0] vec,
  output logic took_slave
);
  initial irq_acknowledge_n = 1'b1;
  // Acknowledges only when told, never from cpu_int
  always @(posedge clk_sys) begin
    if (go) begin
      irq_acknowledge_n <= 1'b0;
      @(posedge clk_sys) irq_acknowledge_n <= 1'b1;
      @(posedge clk_sys) irq_acknowledge_n <= 1'b0;
      @(posedge clk_sys) irq_acknowledge_n <= 1'b1;
      @(posedge clk_sys) vec <= ack_data_oe ? ack_data : 8'hff;
      took_slave <= slave_enable;
    end
  end
endmodule // host_model
`default_nettype wire

/* prio_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module prio_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Inputs
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [7:0] request_in,
  input wire logic [7:0] slave_input,
  input wire logic irq_acknowledge_n,
  // Outputs
  input wire logic cpu_int,
  input wire logic [7:0] ack_data,
  input wire logic ack_data_oe,
  input wire logic slave_enable,
  input wire logic [2:0] slave_select,
  input wire logic irq_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_ack_idle;
    irq_acknowledge_n [*3];
  endsequence
  sequence s_mask_all;
    reg_wr && reg_addr == 3'h4 && reg_wdata == 8'h00 ##1 !(reg_wr && reg_addr == 3'h4);
  endsequence
  a_int_quiet: assert property (request_in == 8'h00 |-> !cpu_int) else $error("int without request");
  a_oe_after_low: assert property (ack_data_oe |-> !$past(irq_acknowledge_n) ||
    !$past(irq_acknowledge_n, 2)) else $error("vector without pulse");
  a_bus_release: assert property (s_ack_idle |-> !ack_data_oe && !slave_enable) else $error("byte held");
  a_one_driver: assert property (!(ack_data_oe && slave_enable)) else $error("two byte drivers");
  a_vector_level: assert property (ack_data_oe |-> ack_data[2:0] == slave_select) else $error("bad level");
  a_slave_marked: assert property (slave_enable |-> slave_input[slave_select]) else $error("plain slave");
  a_direct_plain: assert property (ack_data_oe |-> !slave_input[slave_select]) else $error("slave vector");
  a_irq_masked: assert property (s_mask_all |=> !irq_out) else $error("irq while masked");
endmodule // prio_checker
bind prio_intc prio_checker u_checker (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .request_in, .slave_input,
  .irq_acknowledge_n, .cpu_int, .ack_data, .ack_data_oe, .slave_enable, .slave_select, .irq_out);
`default_nettype wire

/* prio_intc.sv */
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "prio_regs.svh"

// Functional notes
// (RULE_01) Reset starts fully nested priority mode
// (RULE_02) Level 0 highest, 7 lowest initially
// (RULE_03) Acknowledge picks highest, vector, sets in-service
// (RULE_04) In-service holds until end command or auto
// (RULE_05) In-service blocks equal and lower levels
// (RULE_06) Software programs special nesting on master
// (RULE_07) Special nesting lets in-service slave interrupt
// (RULE_08) Normal nesting blocks in-service slave input
// (RULE_09) Software ends slave first, then master
// (RULE_10) Automatic rotation makes serviced level lowest
// (RULE_11) Rotate command ends highest then rotates
// (RULE_12) Rotate-in-auto mode set and cleared
// (RULE_13) Processor disables interrupt input to poll
// (RULE_14) Nonspecific end clears highest in-service bit
// (RULE_15) Poll word: bit7 pending, level bits
// (RULE_16) Slave drives address in second byte
// (RULE_17) Set-priority makes addressed level lowest
// (RULE_18) Read after poll acts as acknowledge
module prio_intc
  import prio_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Requests and cascade
  input wire logic [7:0] request_in,
  input wire logic [7:0] slave_input,
  // Acknowledge, synchronous active low pulses
  input wire logic irq_acknowledge_n,
  output logic cpu_int,
  output logic [7:0] ack_data,
  output logic ack_data_oe,
  output logic slave_enable,
  output logic [2:0] slave_select,
  // Event interrupt
  output logic irq_out
);

  logic [7:0] in_service_reg, in_service_next;
  logic [2:0] lowest_reg, lowest_next;
  logic [7:0] mode_reg;
  logic rotate_auto_reg, rotate_auto_next;
  logic poll_armed_reg;
  ack_state_t ack_state_reg, ack_state_next;
  logic ack_n_d_reg;
  logic [2:0] ack_level_reg;
  logic ack_valid_reg;
  logic [7:0] irq_status_reg, irq_enable_reg;
  logic [7:0] rdata_reg, ack_data_reg;
  logic ack_oe_reg, slave_en_reg;

  // Rotate a vector right so that the highest priority level lands at bit 0
  function automatic logic [7:0] rot_down(input logic [7:0] v, input logic [2:0] hi);
    rot_down = (v >> hi) | (v << (4'h8 - {1'b0, hi}));
  endfunction

  // Index of the first set bit of a rotated vector, mapped back to a level
  function automatic logic [3:0] first_level(input logic [7:0] v, input logic [2:0] hi);
    logic [7:0] r;
    logic [3:0] res;
    r = rot_down(v, hi);
    res = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (r[i]) begin
        res = {1'b0, 3'(i + int'(hi))};
      end
    end
    first_level = res;
  endfunction

  // One-hot decode of a level
  function automatic logic [7:0] level_bit(input logic [2:0] lvl);
    level_bit = 8'h01 << lvl;
  endfunction

  wire [2:0] highest_level = 3'(lowest_reg + 3'h1); // RULE_02
  wire special_nested = mode_reg[`MODE_SPECIAL_NESTED];
  wire auto_eos = mode_reg[`MODE_AUTO_EOS];

  // Highest in-service level, and pending requests that beat it
  wire [3:0] top_service = first_level(in_service_reg, highest_level);
  // In special nesting an in-service cascade input may request again
  wire [7:0] reissue_ok = special_nested ? (in_service_reg & slave_input) : 8'h00; // RULE_07 RULE_08
  wire [7:0] eligible = request_in & (~in_service_reg | reissue_ok);
  wire [3:0] top_request = first_level(eligible, highest_level);
  wire [2:0] dist_req = 3'(top_request[2:0] - highest_level);
  wire [2:0] dist_srv = 3'(top_service[2:0] - highest_level);
  // Equal priority passes only for a reissuing cascade input
  wire beats_service = top_service[3] || (dist_req < dist_srv) ||
    ((dist_req == dist_srv) && reissue_ok[top_service[2:0]]); // RULE_05 RULE_07
  wire request_live = !top_request[3] && beats_service; // RULE_01 RULE_05

  // Command decode
  wire cmd_wr = reg_wr && (reg_addr == `ADDR_CMD);
  wire kind_prio = reg_wdata[`CMD_KIND_HI:`CMD_KIND_LO] == `KIND_PRIORITY;
  wire kind_poll = reg_wdata[`CMD_KIND_HI:`CMD_KIND_LO] == `KIND_POLL_MASK;
  wire cmd_r = reg_wdata[`CMD_ROTATE];
  wire cmd_sl = reg_wdata[`CMD_SELECT];
  wire cmd_eos = reg_wdata[`CMD_EOS];
  wire [2:0] cmd_level = reg_wdata[2:0];
  wire prio_cmd = cmd_wr && kind_prio;
  wire nonspec_eos = prio_cmd && cmd_eos && !cmd_sl; // RULE_11 RULE_14
  wire spec_eos = prio_cmd && cmd_eos && cmd_sl;
  wire set_prio = prio_cmd && cmd_r && cmd_sl; // RULE_17
  wire poll_cmd = cmd_wr && kind_poll && reg_wdata[`CMD_POLL];
  wire poll_read = reg_rd && poll_armed_reg; // RULE_18

  // Acknowledge sequence: first falling edge picks, last rising edge ends
  wire ack_fall = ack_n_d_reg && !irq_acknowledge_n;
  wire ack_rise = !ack_n_d_reg && irq_acknowledge_n;
  wire ack_pick = ack_fall && (ack_state_reg == ack_idle);
  wire ack_last = ack_rise && (ack_state_reg == ack_second);
  wire take = (ack_pick || poll_read) && request_live; // RULE_03 RULE_18
  wire [2:0] take_level = top_request[2:0];
  wire auto_end = ack_last && auto_eos && ack_valid_reg; // RULE_04

  // In-service set and clear strobes, one per level
  wire [7:0] clr_auto = auto_end ? level_bit(ack_level_reg) : 8'h00; // RULE_04
  wire [7:0] clr_nonspec = (nonspec_eos && !top_service[3]) ? level_bit(top_service[2:0]) : 8'h00; // RULE_14
  wire [7:0] clr_spec = spec_eos ? level_bit(cmd_level) : 8'h00;
  wire [7:0] set_take = take ? level_bit(take_level) : 8'h00; // RULE_03
  wire [7:0] is_clear;
  wire [7:0] is_set;
  // A new pick outranks a clear of the same level in one cycle
  for (genvar g = 0; g < 8; g++) begin : g_level
    assign is_clear[g] = clr_auto[g] || clr_nonspec[g] || clr_spec[g];
    assign is_set[g] = set_take[g];
  end

  always_comb begin
    ack_state_next = ack_state_reg;
    unique case (ack_state_reg)
      ack_idle: if (ack_fall) begin
        ack_state_next = ack_first;
      end
      ack_first: if (ack_rise) begin
        ack_state_next = ack_second;
      end
      ack_second: if (ack_rise) begin
        ack_state_next = ack_idle;
      end
      default: ack_state_next = ack_idle;
    endcase
  end

  always_comb begin
    in_service_next = (in_service_reg & ~is_clear) | is_set; // RULE_03 RULE_04 RULE_14
    lowest_next = lowest_reg;
    rotate_auto_next = rotate_auto_reg;
    if (auto_end) begin
      if (rotate_auto_reg) begin
        lowest_next = ack_level_reg; // RULE_10 RULE_12
      end
    end
    if (nonspec_eos && !top_service[3]) begin
      if (cmd_r) begin
        lowest_next = top_service[2:0]; // RULE_10 RULE_11
      end
    end
    if (set_prio) begin
      lowest_next = cmd_level; // RULE_17
    end
    if (prio_cmd && !cmd_sl && !cmd_eos) begin
      rotate_auto_next = cmd_r; // RULE_12
    end
  end

  // Poll word and register reads
  wire [7:0] poll_word = {request_live, 4'h0, take_level}; // RULE_15
  wire [7:0] events = {5'h00, poll_read, prio_cmd && cmd_eos, take && ack_pick};
  wire [7:0] read_mux =
    poll_armed_reg ? poll_word :
    (reg_addr == `ADDR_MODE) ? mode_reg :
    (reg_addr == `ADDR_IRQ_STATUS) ? irq_status_reg :
    (reg_addr == `ADDR_IRQ_ENABLE) ? irq_enable_reg :
    (reg_addr == `ADDR_IN_SERVICE) ? in_service_reg :
    (reg_addr == `ADDR_PENDING) ? request_in :
    (reg_addr == `ADDR_CMD) ? {5'h00, lowest_reg} :
    8'h00;
  wire [7:0] clear_bits = (reg_wr && reg_addr == `ADDR_IRQ_CLEAR) ? reg_wdata : 8'h00;
  // Second byte: own vector, or hand the bus to the cascade partner
  wire second_is_slave = slave_input[ack_level_reg] && ack_valid_reg;
  wire [7:0] vector = {mode_reg[`MODE_VEC_BASE_HI:`MODE_VEC_BASE_LO], ack_level_reg};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      in_service_reg <= 8'h00;
      lowest_reg <= `LOWEST_RESET;
      rotate_auto_reg <= 1'b0;
      ack_state_reg <= ack_idle;
      ack_n_d_reg <= 1'b1;
      ack_valid_reg <= 1'b0;
      ack_level_reg <= 3'h0;
    end else begin
      in_service_reg <= in_service_next;
      lowest_reg <= lowest_next;
      rotate_auto_reg <= rotate_auto_next;
      ack_state_reg <= ack_state_next;
      ack_n_d_reg <= irq_acknowledge_n;
      if (ack_pick) begin
        ack_valid_reg <= take;
        ack_level_reg <= take ? take_level : 3'h7;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_reg <= `MODE_RESET;
      poll_armed_reg <= 1'b0;
      irq_status_reg <= 8'h00;
      irq_enable_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `ADDR_MODE) begin
        mode_reg <= reg_wdata;
      end
      if (poll_cmd) begin
        poll_armed_reg <= 1'b1;
      end else if (reg_rd) begin
        poll_armed_reg <= 1'b0;
      end
      if (reg_wr && reg_addr == `ADDR_IRQ_ENABLE) begin
        irq_enable_reg <= reg_wdata;
      end
      irq_status_reg <= (irq_status_reg & ~clear_bits) | events;
      if (reg_rd) begin
        rdata_reg <= read_mux; // RULE_15
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_data_reg <= 8'h00;
      ack_oe_reg <= 1'b0;
      slave_en_reg <= 1'b0;
    end else begin
      ack_oe_reg <= 1'b0;
      slave_en_reg <= 1'b0;
      if (ack_state_reg == ack_second && !irq_acknowledge_n) begin
        slave_en_reg <= second_is_slave; // RULE_16
        ack_oe_reg <= !second_is_slave;
        ack_data_reg <= vector; // RULE_03
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign cpu_int = request_live; // RULE_05 RULE_07
  assign ack_data = ack_data_reg;
  assign ack_data_oe = ack_oe_reg;
  assign slave_enable = slave_en_reg;
  assign slave_select = ack_level_reg;
  assign irq_out = |(irq_status_reg & irq_enable_reg);

endmodule // prio_intc

`default_nettype wire

/* prio_intc_test.sv */
`timescale 1ns/100ps
`default_nettype none
module prio_intc_test;
  logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, go = 0;
  logic [2:0] reg_addr = 3'h0, slave_select;
  logic [7:0] reg_wdata = 8'h00, request_in = 8'h00, slave_input = 8'h00, reg_rdata, ack_data, vec;
  logic irq_acknowledge_n, cpu_int, ack_data_oe, slave_enable, irq_out, took_slave;
  int n_fail = 0, checks = 0;
  always #20 clk_sys = ~clk_sys;
  prio_intc DUT (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .request_in,
    .slave_input, .irq_acknowledge_n, .cpu_int, .ack_data, .ack_data_oe, .slave_enable, .slave_select, .irq_out);
  host_model host (.clk_sys, .go, .ack_data, .ack_data_oe, .slave_enable, .irq_acknowledge_n, .vec, .took_slave);
  task chk(input string s, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys) reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys) reg_rd <= 1'b0;
    @(posedge clk_sys) chk("reg_rdata", e, reg_rdata);
  endtask
  task ack(input logic [7:0] e);
    go <= 1'b1;
    @(posedge clk_sys) go <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("vector", e, vec);
  endtask
  task flags(input logic ei, eo);
    repeat (2) @(posedge clk_sys);
    chk("cpu_int", {7'h00, ei}, {7'h00, cpu_int});
    chk("irq_out", {7'h00, eo}, {7'h00, irq_out});
  endtask
  task test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk_sys);
    n_fail++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(3'h6, 8'h00);
    rd(3'h0, 8'h07);
    rd(3'h1, 8'h00);
    wr(3'h2, 8'h08);
    request_in <= 8'h24;
    ack(8'h0a);
    rd(3'h6, 8'h04);
    flags(1'b0, 1'b0);
    request_in <= 8'h25;
    flags(1'b1, 1'b0);
    ack(8'h08);
    wr(3'h0, 8'h20);
    rd(3'h6, 8'h04);
    wr(3'h0, 8'h20);
    request_in <= 8'h04;
    ack(8'h0a);
    wr(3'h0, 8'ha0);
    rd(3'h6, 8'h00);
    rd(3'h0, 8'h02);
    request_in <= 8'h0a;
    ack(8'h0b);
    wr(3'h0, 8'hc5);
    rd(3'h0, 8'h05);
    request_in <= 8'h41;
    ack(8'h0e);
    wr(3'h0, 8'h20);
    rd(3'h6, 8'h08);
    wr(3'h0, 8'h20);
    wr(3'h0, 8'hc7);
    wr(3'h2, 8'h09);
    wr(3'h0, 8'h80);
    request_in <= 8'h02;
    ack(8'h09);
    rd(3'h6, 8'h00);
    rd(3'h0, 8'h01);
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h08);
    wr(3'h0, 8'hc7);
    request_in <= 8'h10;
    wr(3'h0, 8'h0c);
    rd(3'h7, 8'h84);
    rd(3'h6, 8'h10);
    wr(3'h0, 8'h20);
    request_in <= 8'h00;
    slave_input <= 8'h04;
    wr(3'h2, 8'h0a);
    request_in <= 8'h04;
    ack(8'hff);
    chk("took_slave", 8'h01, {7'h00, took_slave});
    flags(1'b1, 1'b0);
    wr(3'h2, 8'h08);
    flags(1'b0, 1'b0);
    wr(3'h0, 8'h20);
    rd(3'h6, 8'h00);
    request_in <= 8'h00;
    rd(3'h3, 8'h07);
    wr(3'h4, 8'h02);
    flags(1'b0, 1'b1);
    wr(3'h4, 8'h00);
    flags(1'b0, 1'b0);
    wr(3'h5, 8'h07);
    wr(3'h4, 8'h07);
    flags(1'b0, 1'b0);
    rd(3'h3, 8'h00);
    test_done;
  end
endmodule // prio_intc_test
`default_nettype wire

/* prio_pkg.sv */
package prio_pkg;
  typedef enum logic [1:0] {
    ack_idle = 2'b00,
    ack_first = 2'b01,
    ack_second = 2'b11
  } ack_state_t;
endpackage

/* prio_regs.svh */
`ifndef PRIO_REGS_SVH
`define PRIO_REGS_SVH
// Register index on the plain port
`define ADDR_CMD 3'h0
`define ADDR_POLL 3'h1
`define ADDR_MODE 3'h2
`define ADDR_IRQ_STATUS 3'h3
`define ADDR_IRQ_ENABLE 3'h4
`define ADDR_IRQ_CLEAR 3'h5
`define ADDR_IN_SERVICE 3'h6
`define ADDR_PENDING 3'h7
// Priority command word fields
`define CMD_ROTATE 7
`define CMD_SELECT 6
`define CMD_EOS 5
`define CMD_POLL 2
`define CMD_KIND_HI 4
`define CMD_KIND_LO 3
`define KIND_PRIORITY 2'h0
`define KIND_POLL_MASK 2'h1
// Mode register fields
`define MODE_AUTO_EOS 0
`define MODE_SPECIAL_NESTED 1
`define MODE_VEC_BASE_HI 7
`define MODE_VEC_BASE_LO 3
// Reset values
`define MODE_RESET 8'h00
`define LOWEST_RESET 3'h7
// Status events
`define EV_ACK 0
`define EV_EOS 1
`define EV_POLL 2
`endif
